// file: rtl/rdi_receive_data_if.sv
// receive data interface: mode select, pin data and strobes, buffer word, external processing
`timescale 1ns/1ps
module rdi_receive_data_if
   import rdi_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // register bus
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // demodulator pins, outside this clock domain
   input  wire logic        chip_clk_in,
   input  wire logic        chip_data_in,
   input  wire logic        filter_sign_in,
   input  wire logic        slicer_in,
   // digital receiver, same clock
   input  wire logic        rx_active,
   input  wire logic        payload_phase,
   input  wire logic        decoded_bit,
   input  wire logic        decoded_bit_valid,
   input  wire logic [7:0]  signal_strength_level,
   input  wire logic        wake_check,
   input  wire logic        data_available,
   input  wire logic        fsync_irq_in,
   input  wire logic        mid_irq_in,
   input  wire logic        eom_irq_in,
   // pins towards the controller
   output logic             decoded_bit_out,
   output logic             decoded_bit_strobe,
   output logic             chip_stream_out,
   output logic             chip_clock_estimate,
   output logic             filter_out,
   output logic             slicer_out,
   output logic             interrupt_out_n,
   // towards the framer and polling scheduler
   output logic             framer_path_open,
   output logic             fsync_irq_out,
   output logic             mid_irq_out,
   output logic             eom_irq_out,
   output logic             timeout_counter_enable,
   output logic             data_wakeup_enable,
   output logic             run_mode_self_poll,
   output logic             external_timeout_command,
   output logic             external_message_end_command
);

   rdi_state_t st;
   rdi_state_t next_st;
   logic       addr_ok;
   logic       rd_req;
   logic       wr_do;
   logic       in_win;
   logic       bit_take;
   logic       rx_clear;
   logic       stat_clear;
   logic       cmd_to;
   logic       cmd_eom;
   logic       chip_rise;
   logic       bit_start;
   logic       chip_start;
   logic       bit_str_raw;
   logic       chip_str_raw;
   logic [4:0] base_cnt;

   // the bus always answers in zero wait states with OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = st.hrdata;

   // strobe generators for payload bits and chips
   rdi_strobe_gen #(.DLY_SHIFT(RDI_BIT_DLY_SHIFT)) u_bit_strobe (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .start   (bit_start),
      .period  (st.bit_period),
      .strobe  (bit_str_raw)
   );

   rdi_strobe_gen #(.DLY_SHIFT(RDI_CHIP_DLY_SHIFT)) u_chip_strobe (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .start   (chip_start),
      .period  (st.chip_period),
      .strobe  (chip_str_raw)
   );

   // decode of bus phases and block events
   always_comb begin
      addr_ok    = hsel && htrans[1] && hready;
      rd_req     = addr_ok && !hwrite;
      wr_do      = st.wr_pend;
      in_win     = (signal_strength_level >= st.signal_strength_level_lo)
                && (signal_strength_level <= st.signal_strength_level_hi);
      rx_clear   = rd_req && (haddr[7:0] == RDI_OFS_RX_DATA);
      stat_clear = rd_req && (haddr[7:0] == RDI_OFS_STATUS);
      cmd_to     = wr_do && (st.wr_addr == RDI_OFS_CMD) && hwdata[RDI_CMD_TIMEOUT_POS];
      cmd_eom    = wr_do && (st.wr_addr == RDI_OFS_CMD) && hwdata[RDI_CMD_EOM_POS];
      // only payload bits reach the word, headers and wake-up frames never do
      bit_take   = decoded_bit_valid && payload_phase && rx_active
                && ((st.mode == packet_buffered_mode)
                 || (st.mode == packet_transparent_payload_mode));
      chip_rise  = st.sync2[0] && !st.chip_clk_d;
      bit_start  = bit_take && (st.mode == packet_transparent_payload_mode);
      chip_start = chip_rise && st.chip_str_en && rx_active
                && (st.mode == transparent_chip_strobe_mode);
      base_cnt   = rx_clear ? 5'h00 : st.rx_count;
   end

   // next state of the whole block
   always_comb begin
      next_st = st;
      next_st.timeout_pulse = 1'b0;
      next_st.msg_end_pulse = 1'b0;
      // two flip-flops on every demodulator pin; stage one feeds stage two only
      next_st.sync1 = {slicer_in, filter_sign_in, chip_data_in, chip_clk_in};
      next_st.sync2 = st.sync1;
      next_st.chip_clk_d = st.sync2[0];
      // pin data held low while the receiver rests
      if (!rx_active) begin
         next_st.chip_q  = 1'b0;
         next_st.bit_q   = 1'b0;
         next_st.filt_q  = 1'b0;
         next_st.slice_q = 1'b0;
      end else begin
         if (chip_rise) next_st.chip_q = st.sync2[1];
         if (bit_start) next_st.bit_q = decoded_bit;
         next_st.filt_q  = st.sync2[2];
         next_st.slice_q = st.sync2[3];
      end
      // buffer word: a bit arriving with the clearing read lands at position zero
      if (rx_clear) begin
         next_st.rx_word  = '0;
         next_st.rx_count = 5'h00;
         next_st.rx_ovf   = 1'b0;
      end
      if (bit_take) begin
         if (base_cnt < RDI_RX_FULL) begin
            next_st.rx_word[base_cnt] = decoded_bit;
            next_st.rx_count = base_cnt + 5'h01;
         end else begin
            next_st.rx_ovf = 1'b1;
         end
      end
      // pending flags: reading status clears, a new event in that cycle still wins
      if (stat_clear) begin
         next_st.wake_pend = 1'b0;
         next_st.data_pend = 1'b0;
      end
      // polling states under external processing
      case (st.poll)
         poll_self: begin
            if (st.ext_proc && wake_check && in_win) begin
               next_st.poll      = poll_run;
               next_st.wake_pend = 1'b1;
            end
         end
         poll_run: begin
            if (data_available && in_win) next_st.data_pend = 1'b1;
            if (cmd_to) begin
               next_st.poll          = poll_self;
               next_st.timeout_pulse = 1'b1;
            end else if (cmd_eom) begin
               next_st.poll          = poll_self;
               next_st.msg_end_pulse = 1'b1;
            end
         end
         default: next_st.poll = poll_self;
      endcase
      // read data is prepared in the address phase so it stands in the data phase
      if (rd_req) begin
         case (haddr[7:0])
            RDI_OFS_CTRL:     next_st.hrdata = {27'h0, st.chip_str_en, st.ext_proc, st.mode};
            RDI_OFS_POLARITY: next_st.hrdata = {29'h0, st.int_high, st.chip_inv, st.bit_inv};
            RDI_OFS_BIT_PER:  next_st.hrdata = {16'h0, st.bit_period};
            RDI_OFS_CHIP_PER: next_st.hrdata = {16'h0, st.chip_period};
            RDI_OFS_WINDOW:   next_st.hrdata = {16'h0, st.signal_strength_level_hi, st.signal_strength_level_lo};
            RDI_OFS_STATUS:   next_st.hrdata = {28'h0, st.poll, st.data_pend, st.wake_pend};
            RDI_OFS_RX_DATA:  next_st.hrdata = {st.rx_ovf, 2'b00, st.rx_count,
                                                st.rx_word};
            default:          next_st.hrdata = 32'h0;
         endcase
      end
      // write address captured now, data applied in the next cycle
      next_st.wr_pend = addr_ok && hwrite;
      if (addr_ok && hwrite) next_st.wr_addr = haddr[7:0];
      if (wr_do) begin
         case (st.wr_addr)
            RDI_OFS_CTRL: begin
               // unknown mode codes fall back to the buffered mode
               if (hwdata[2:0] <= 3'h4) next_st.mode = rdi_mode_t'(hwdata[2:0]);
               else                     next_st.mode = packet_buffered_mode;
               next_st.ext_proc    = hwdata[RDI_CTRL_EXT_POS];
               next_st.chip_str_en = hwdata[RDI_CTRL_CHSTR_POS];
            end
            RDI_OFS_POLARITY: begin
               next_st.bit_inv  = hwdata[RDI_POL_BIT_POS];
               next_st.chip_inv = hwdata[RDI_POL_CHIP_POS];
               next_st.int_high = hwdata[RDI_POL_INT_POS];
            end
            RDI_OFS_BIT_PER:  next_st.bit_period  = hwdata[15:0];
            RDI_OFS_CHIP_PER: next_st.chip_period = hwdata[15:0];
            RDI_OFS_WINDOW: begin
               next_st.signal_strength_level_lo = hwdata[7:0];
               next_st.signal_strength_level_hi = hwdata[15:8];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st             <= '0;
         st.mode        <= packet_buffered_mode;
         st.poll        <= poll_self;
         st.bit_period  <= RDI_RST_BIT_PER;
         st.chip_period <= RDI_RST_CHIP_PER;
         st.signal_strength_level_lo     <= RDI_RST_SIGNAL_STRENGTH_LEVEL_LO;
         st.signal_strength_level_hi     <= RDI_RST_SIGNAL_STRENGTH_LEVEL_HI;
      end else begin
         st <= next_st;
      end
   end

   // pins: outputs of modes not selected sit at their inactive level
   always_comb begin
      decoded_bit_out     = (st.mode == packet_transparent_payload_mode) && st.bit_q;
      decoded_bit_strobe  = ((st.mode == packet_transparent_payload_mode) && bit_str_raw)
                          ^ st.bit_inv;
      chip_stream_out     = (st.mode == transparent_chip_strobe_mode) && st.chip_q;
      chip_clock_estimate = ((st.mode == transparent_chip_strobe_mode) && chip_str_raw)
                          ^ st.chip_inv;
      filter_out          = (st.mode == transparent_filter_mode) && st.filt_q;
      slicer_out          = (st.mode == transparent_slicer_mode) && st.slice_q;
      // one level for both wake-up and data; default active low
      interrupt_out_n     = (st.wake_pend || st.data_pend) ~^ st.int_high;
   end

   // external processing opens the framer path and silences frame events
   always_comb begin
      framer_path_open            = st.ext_proc;
      fsync_irq_out               = fsync_irq_in && !st.ext_proc;
      mid_irq_out                 = mid_irq_in && !st.ext_proc;
      eom_irq_out                 = eom_irq_in && !st.ext_proc;
      timeout_counter_enable      = !st.ext_proc;
      data_wakeup_enable          = !st.ext_proc;
      run_mode_self_poll          = (st.poll == poll_run);
      external_timeout_command    = st.timeout_pulse;
      external_message_end_command = st.msg_end_pulse;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   AST_MODE_LEGAL: assert property (st.mode inside {packet_buffered_mode,
         packet_transparent_payload_mode, transparent_chip_strobe_mode,
         transparent_filter_mode, transparent_slicer_mode})
      else $error("receive mode left the five legal codes");

   AST_BUF_COUNT: assert property (bit_take && !rx_clear && (st.rx_count < RDI_RX_FULL)
         |=> st.rx_count == $past(st.rx_count) + 5'h01)
      else $error("stored bit did not advance the count");

   AST_DATA_LOW_IDLE: assert property (!rx_active |=> (!decoded_bit_out && !chip_stream_out))
      else $error("data pin not low while receiver inactive");

   AST_IDLE_STROBE: assert property ((st.mode != transparent_chip_strobe_mode)
         |-> (chip_clock_estimate == st.chip_inv) && !chip_stream_out)
      else $error("chip pins active outside chip mode");

   AST_WAKE_WIN: assert property ((st.poll == poll_self) && st.ext_proc && wake_check
         && in_win |=> run_mode_self_poll ##0 (interrupt_out_n == st.int_high))
      else $error("in-window strength did not wake the device");

   AST_NO_WAKE: assert property ((st.poll == poll_self) && !in_win && !st.wake_pend
         |=> !st.wake_pend && !run_mode_self_poll)
      else $error("out-of-window strength raised a wake-up");

   AST_DATA_IRQ: assert property ((st.poll == poll_run) && data_available && in_win
         |=> st.data_pend && (interrupt_out_n == st.int_high))
      else $error("data in window did not raise the interrupt");

   AST_TIMEOUT: assert property ((st.poll == poll_run) && cmd_to
         |=> external_timeout_command && !run_mode_self_poll ##1 !external_timeout_command)
      else $error("timeout command did not return to self polling");

   AST_EOM: assert property ((st.poll == poll_run) && cmd_eom && !cmd_to
         |=> external_message_end_command && !run_mode_self_poll)
      else $error("end-of-message command not honoured");

   AST_SUPPRESS: assert property (st.ext_proc |-> framer_path_open && !fsync_irq_out
         && !mid_irq_out && !eom_irq_out && !timeout_counter_enable)
      else $error("frame events not suppressed under external processing");

endmodule : rdi_receive_data_if

// file: pkg/rdi_pkg.sv
// package for the receive data interface: register map, reset values, modes, state types
package rdi_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] RDI_OFS_CTRL      = 8'h00;
   localparam logic [7:0] RDI_OFS_POLARITY  = 8'h04;
   localparam logic [7:0] RDI_OFS_BIT_PER   = 8'h08;
   localparam logic [7:0] RDI_OFS_CHIP_PER  = 8'h0C;
   localparam logic [7:0] RDI_OFS_WINDOW    = 8'h10;
   localparam logic [7:0] RDI_OFS_CMD       = 8'h14;
   localparam logic [7:0] RDI_OFS_STATUS    = 8'h18;
   localparam logic [7:0] RDI_OFS_RX_DATA   = 8'h1C;

   // field positions
   localparam int RDI_CTRL_EXT_POS    = 3;
   localparam int RDI_CTRL_CHSTR_POS  = 4;
   localparam int RDI_POL_BIT_POS     = 0;
   localparam int RDI_POL_CHIP_POS    = 1;
   localparam int RDI_POL_INT_POS     = 2;
   localparam int RDI_CMD_TIMEOUT_POS = 0;
   localparam int RDI_CMD_EOM_POS     = 1;

   // values after reset
   localparam logic [15:0] RDI_RST_BIT_PER  = 16'h0100;
   localparam logic [15:0] RDI_RST_CHIP_PER = 16'h0080;
   localparam logic [7:0]  RDI_RST_SIGNAL_STRENGTH_LEVEL_LO  = 8'h00;
   localparam logic [7:0]  RDI_RST_SIGNAL_STRENGTH_LEVEL_HI  = 8'hFF;

   // receive word capacity and the count at which the word is full
   localparam int          RDI_RX_BITS = 24;
   localparam logic [4:0]  RDI_RX_FULL = 5'h18;

   // strobe delay as a right shift of the period: period/16 and period/8
   localparam int RDI_BIT_DLY_SHIFT  = 4;
   localparam int RDI_CHIP_DLY_SHIFT = 3;

   // the five receive modes
   typedef enum logic [2:0] {
      packet_buffered_mode            = 3'h0,
      packet_transparent_payload_mode = 3'h1,
      transparent_chip_strobe_mode    = 3'h2,
      transparent_filter_mode         = 3'h3,
      transparent_slicer_mode         = 3'h4
   } rdi_mode_t;

   // polling state, one-hot
   typedef enum logic [1:0] {
      poll_self = 2'b01,
      poll_run  = 2'b10
   } rdi_poll_t;

   // strobe generator state
   typedef struct packed {
      logic [16:0] cnt;
      logic        busy;
      logic        out;
   } rdi_strobe_st_t;

   // main block state
   typedef struct packed {
      rdi_mode_t   mode;
      logic        ext_proc;
      logic        chip_str_en;
      logic        bit_inv;
      logic        chip_inv;
      logic        int_high;
      logic [15:0] bit_period;
      logic [15:0] chip_period;
      logic [7:0]  signal_strength_level_lo;
      logic [7:0]  signal_strength_level_hi;
      rdi_poll_t   poll;
      logic        wake_pend;
      logic        data_pend;
      logic [23:0] rx_word;
      logic [4:0]  rx_count;
      logic        rx_ovf;
      logic [31:0] hrdata;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      logic        chip_clk_d;
      logic        chip_q;
      logic        bit_q;
      logic        filt_q;
      logic        slice_q;
      logic        timeout_pulse;
      logic        msg_end_pulse;
   } rdi_state_t;

endpackage : rdi_pkg

// file: rtl/rdi_strobe_gen.sv
// strobe pulse generator: delay and width derived from a programmable period
`timescale 1ns/1ps
module rdi_strobe_gen
   import rdi_pkg::*;
#(
   parameter int DLY_SHIFT = 4
) (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        start,
   input  wire logic [15:0] period,
   output logic             strobe
);

   rdi_strobe_st_t st;
   rdi_strobe_st_t next_st;
   logic [16:0]    dly;
   logic [16:0]    wid;
   logic [16:0]    stop;

   // a zero period would give no pulse at all, so both phases keep one cycle
   always_comb begin
      dly  = {1'b0, period >> DLY_SHIFT};
      wid  = {2'b00, period[15:1]};
      if (dly == 17'h00000) dly = 17'h00001;
      if (wid == 17'h00000) wid = 17'h00001;
      stop = dly + wid;
      next_st = st;
      if (start) begin
         next_st.cnt  = 17'h00000;
         next_st.busy = 1'b1;
         next_st.out  = 1'b0;
      end else if (st.busy) begin
         next_st.cnt  = st.cnt + 17'h00001;
         next_st.out  = (next_st.cnt >= dly) && (next_st.cnt < stop);
         next_st.busy = next_st.cnt < stop;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) st <= '0;
      else          st <= next_st;
   end

   assign strobe = st.out;

endmodule : rdi_strobe_gen

// file: bench/rdi_demod_model.sv
// demodulator stand-in: sends one frame of chips with its own chip clock
`timescale 1ns/1ps
module rdi_demod_model (
   input  wire logic       start,
   input  wire logic [7:0] chips,
   output logic            chip_clk,
   output logic            chip_data
);
   // clock stands low outside frames; data shows the inverse of its last chip once the frame ends
   initial begin
      chip_clk = 1'b0;
      chip_data = 1'b0;
   end
   always @(posedge start) begin
      for (int i = 0; i < 8; i++) begin
         chip_data = chips[i];
         #32 chip_clk = 1'b1;
         #32 chip_clk = 1'b0;
      end
      chip_data = ~chip_data;
   end
endmodule : rdi_demod_model

// file: bench/test_rdi_receive_data_if.sv
// self-checking bench for the receive data interface
`timescale 1ns/1ps
module test_rdi_receive_data_if import rdi_pkg::*;;
   logic        clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, start;
   logic        cclk, cdat, fsgn, slc, rxa, pay, dbit, dval, wchk, dav, fs;
   logic        dbo, dbs, cso, cce, fo, so, intn, fpo, fso, tce, rms, eto, emc;
   logic [1:0]  htrans;
   logic [7:0]  ssl, chips;
   logic [31:0] haddr, hwdata, hrdata, q;
   int          n_errors, checks_done, n_to, n_eom;

   rdi_receive_data_if DUT (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chip_clk_in(cclk),
      .chip_data_in(cdat), .filter_sign_in(fsgn), .slicer_in(slc), .rx_active(rxa),
      .payload_phase(pay), .decoded_bit(dbit), .decoded_bit_valid(dval),
      .signal_strength_level(ssl), .wake_check(wchk), .data_available(dav),
      .fsync_irq_in(fs), .mid_irq_in(1'b0), .eom_irq_in(1'b0), .decoded_bit_out(dbo),
      .decoded_bit_strobe(dbs), .chip_stream_out(cso), .chip_clock_estimate(cce),
      .filter_out(fo), .slicer_out(so), .interrupt_out_n(intn), .framer_path_open(fpo),
      .fsync_irq_out(fso), .mid_irq_out(), .eom_irq_out(), .timeout_counter_enable(tce),
      .data_wakeup_enable(), .run_mode_self_poll(rms), .external_timeout_command(eto),
      .external_message_end_command(emc));
   rdi_demod_model partner (.start(start), .chips(chips), .chip_clk(cclk), .chip_data(cdat));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // command pulses are one cycle wide, so they are counted rather than sampled
   always @(posedge clk_sys) begin
      if (eto === 1'b1) n_to++;
      if (emc === 1'b1) n_eom++;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask : cyc
   // one single-word transfer; read data lands in q at the end of the data phase
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= w;
      do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 20);
      htrans <= 2'h0; hwdata <= d;
      do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 40);
      q = hrdata;
      if (n >= 20) begin n_errors++; give_verdict(); end
   endtask : bus
   // one-cycle pulse: 0 payload bit, 1 wake check, 2 data available
   task pl(input int s, input logic b);
      dbit <= b;
      if (s == 0) dval <= 1'b1; else if (s == 1) wchk <= 1'b1; else dav <= 1'b1;
      @(posedge clk_sys);
      dval <= 1'b0; wchk <= 1'b0; dav <= 1'b0;
      @(posedge clk_sys);
   endtask : pl

   task t_reset;
      chk(intn, 1'b1); chk(dbo, 1'b0);
      chk(hresp, 1'b0);
      bus(0, RDI_OFS_CTRL, 0); chk(q, 32'h0);
      bus(0, RDI_OFS_BIT_PER, 0); chk(q, {16'h0000, RDI_RST_BIT_PER});
      bus(0, RDI_OFS_CHIP_PER, 0); chk(q, {16'h0000, RDI_RST_CHIP_PER});
      bus(0, RDI_OFS_WINDOW, 0); chk(q, 32'h0000FF00);
      bus(0, 8'h40, 0); chk(q, 32'h0);
      $display("reset test done");
   endtask : t_reset
   // header bits are dropped, payload bits stored first-in at bit0, word cleared by each read
   task t_buffer;
      pl(0, 1'b1);
      pay <= 1'b1;
      pl(0, 1'b1); pl(0, 1'b0); pl(0, 1'b1);
      chk(dbo, 1'b0);
      bus(0, RDI_OFS_RX_DATA, 0); chk(q, 32'h03000005);
      bus(0, RDI_OFS_RX_DATA, 0); chk(q, 32'h0);
      // one bit past the word's capacity only sets the overflow flag
      repeat (RDI_RX_BITS + 1) pl(0, 1'b1);
      bus(0, RDI_OFS_RX_DATA, 0); chk(q, 32'h98FFFFFF);
      bus(0, RDI_OFS_RX_DATA, 0); chk(q, 32'h0);
      $display("buffer test done");
   endtask : t_buffer
   task t_payload;
      int k, rise, wid;
      rise = 0; wid = 0;
      bus(1, RDI_OFS_BIT_PER, 32'h20); bus(1, RDI_OFS_CTRL, 32'h1);
      dbit <= 1'b1; dval <= 1'b1;
      @(posedge clk_sys);
      dval <= 1'b0;
      // k counts cycles after the bit was taken
      for (k = 1; k < 60; k++) begin
         #1;
         if (k == 1) chk(dbo, 1'b1);
         if (dbs === 1'b1) begin if (wid == 0) rise = k; wid++; end
         @(posedge clk_sys);
      end
      chk(rise, (32'h20 >> RDI_BIT_DLY_SHIFT) + 1); chk(wid, 32'h10);
      bus(1, RDI_OFS_POLARITY, 32'h1); cyc(2); chk(dbs, 1'b1);
      bus(1, RDI_OFS_POLARITY, 32'h0);
      rxa <= 1'b0; cyc(3); chk(dbo, 1'b0);
      rxa <= 1'b1;
      $display("payload test done");
   endtask : t_payload
   task t_chip;
      int k, wid;
      wid = 0;
      bus(1, RDI_OFS_CHIP_PER, 32'h10); bus(1, RDI_OFS_CTRL, 32'h12);
      #1.3 chips = 8'hAA;
      start = 1'b1;
      for (k = 0; k < 170; k++) begin @(posedge clk_sys); #1; if (cce === 1'b1) wid++; end
      start = 1'b0;
      chk(cso, 1'b1); chk(wid, 8 * (32'h10 >> 1));
      bus(1, RDI_OFS_CTRL, 32'h0); cyc(2); chk(cso, 1'b0); chk(cce, 1'b0);
      $display("chip test done");
   endtask : t_chip
   // no self polling is set up in these modes, as they allow only level wake-up
   task t_filt;
      fsgn <= 1'b1; slc <= 1'b0;
      bus(1, RDI_OFS_CTRL, 32'h3); cyc(6); chk(fo, 1'b1); chk(so, 1'b0);
      slc <= 1'b1;
      bus(1, RDI_OFS_CTRL, 32'h4); cyc(6); chk(so, 1'b1); chk(fo, 1'b0);
      // an unknown mode code falls back to the buffered mode
      bus(1, RDI_OFS_CTRL, 32'h7); bus(0, RDI_OFS_CTRL, 0); chk(q, 32'h0);
      $display("filter test done");
   endtask : t_filt
   // the external set is the only and last one, its timers left to the controller
   task t_ext;
      bus(1, RDI_OFS_WINDOW, 32'h8040); bus(1, RDI_OFS_CTRL, 32'h8);
      fs <= 1'b1; cyc(2);
      chk(fpo, 1'b1); chk(fso, 1'b0); chk(tce, 1'b0);
      fs <= 1'b0; ssl <= 8'h20;
      pl(1, 1'b0); chk(rms, 1'b0); chk(intn, 1'b1);
      ssl <= 8'h60;
      pl(1, 1'b0); chk(rms, 1'b1);
      bus(0, RDI_OFS_STATUS, 0); chk(q, 32'h9);
      cyc(2); chk(intn, 1'b1);
      pl(2, 1'b0); chk(intn, 1'b0);
      bus(1, RDI_OFS_POLARITY, 32'h4); cyc(1); chk(intn, 1'b1);
      bus(0, RDI_OFS_STATUS, 0); chk(q, 32'hA);
      cyc(1); chk(intn, 1'b0);
      bus(1, RDI_OFS_POLARITY, 32'h0);
      bus(1, RDI_OFS_CMD, 32'h1); cyc(3); chk(rms, 1'b0); chk(n_to, 1);
      pl(1, 1'b0);
      bus(1, RDI_OFS_CMD, 32'h2); cyc(3); chk(rms, 1'b0); chk(n_eom, 1);
      $display("external processing test done");
   endtask : t_ext

   initial begin
      reset_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hwdata = 32'h0; start = 1'b0; chips = 8'h00; fsgn = 1'b0; slc = 1'b0; rxa = 1'b1;
      pay = 1'b0; dbit = 1'b0; dval = 1'b0; wchk = 1'b0; dav = 1'b0; fs = 1'b0; ssl = 8'h00;
      n_errors = 0; checks_done = 0; n_to = 0; n_eom = 0;
      cyc(16);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      t_reset(); t_buffer(); t_payload(); t_chip(); t_filt(); t_ext();
      give_verdict();
   end
endmodule : test_rdi_receive_data_if
